// >>> logic/an_ctrl_pkg.sv
package an_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEED = 8'h04;
    localparam logic [7:0] ADDR_LNP_LO = 8'h08;
    localparam logic [7:0] ADDR_LNP_HI = 8'h0C;
    localparam logic [7:0] ADDR_ACK = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_PNP_LO = 8'h18;
    localparam logic [7:0] ADDR_PNP_HI = 8'h1C;
    localparam logic [7:0] ADDR_TXCW_LO = 8'h20;
    localparam logic [7:0] ADDR_TXCW_HI = 8'h24;
    // Control register field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_BYPASS = 1;
    localparam int CTRL_RESTART = 2;
    localparam int CTRL_POLY_SEL = 3;
    localparam int CTRL_FAULT = 4;
    localparam int CTRL_PAUSE = 5;
    localparam int CTRL_ASYM = 6;
    localparam int CTRL_LOC_NP = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SEED_RESET = 8'h01;
    localparam logic [6:0] RAND_RESET = 7'h7F;
    // Link codeword layout
    localparam int CW_W = 50;
    localparam int CW_RAND = 49;
    localparam int CW_NONCE_LSB = 43;
    localparam int CW_ECHO_LSB = 5;
    localparam int CW_C0 = 10;
    localparam int CW_C1 = 11;
    localparam int CW_FAULT = 13;
    localparam int CW_ACK = 14;
    localparam int CW_NP = 15;
    localparam logic [4:0] SELECTOR_ETH = 5'h01;
    localparam logic [10:0] NULL_MSG_CODE = 11'h001;
    localparam int LNP_W = 48;
    // Negotiation states
    typedef enum logic [2:0] {
        st_off,
        st_bypass,
        st_base,
        st_next,
        st_good
    } an_state_e;
endpackage

// >>> logic/backplane_autoneg_control.sv
// Operation
// - Negotiation runs only while the enable bit is set.
// - Bypass, with the enable bit also set, turns negotiation off and connects the PCS straight through.
// - The nonce generator is loaded from the 8-bit seed.
// - Codeword bit 49 random source uses x^7+x^6+1 or x^7+x^3+1.
// - Restart returns negotiation to the base page from any state, unless the enable bit is clear or bypass is set.
// - Local fault input is copied into the codeword fault bit.
// - Pause ability drives codeword bit C0.
// - Asymmetric direction ability drives codeword bit C1.
// - With local next page set, the local next page word is sent.
// - With local next page clear, a next page exchange starts only if the partner base page sets its NP bit.
// - Partner next pages with local flag clear are answered with null pages.
// - Rising acknowledge acknowledges partner page and starts the next codeword.
// - After acknowledge, partner page valid stays low until a new page arrives.
// - Negotiation done waits for PCS receive status.
`timescale 1ns/1ns
`default_nettype none
module backplane_autoneg_control
    import an_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [CW_W-1:0] rx_codeword_in,
    input wire logic rx_page_valid_in,
    input wire logic pcs_rx_status_in,
    output logic [CW_W-1:0] tx_codeword_out,
    output logic tx_page_enable_out,
    output logic pcs_bypass_out,
    output logic negotiation_done_out,
    output logic partner_nextpage_valid_out
);
    // Bus capture and control registers
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [7:0] ctrl_q;
    logic [7:0] nonce_seed_in;
    logic [LNP_W-1:0] local_nextpage_word_in;
    logic partner_nextpage_ack_in;
    logic ack_prev_q;
    logic restart_q;
    logic [31:0] rdata_d;
    // Link side
    logic [CW_W-1:0] rxcw_s1_q;
    logic [CW_W-1:0] rxcw_s2_q;
    logic [2:0] rxv_q;
    logic [1:0] pcs_st_q;
    logic [CW_W-1:0] partner_nextpage_word_out;
    logic [CW_W-1:0] tx_cw_d;
    an_state_e state_q;
    logic [7:0] nonce_q;
    logic [6:0] rand_q;
    logic cw_ack_q;
    logic page_evt;
    logic ack_rise;
    logic addr_ok;

    // Galois-free Fibonacci step for the 7-bit random source
    function automatic logic [6:0] rand_step(input logic [6:0] s, input logic sel);
        logic fb;
        fb = 1'b0;
        fb = sel ? (s[6] ^ s[5]) : (s[6] ^ s[2]);
        rand_step = {s[5:0], fb};
    endfunction

    // Nonce generator, taps 8,6,5,4
    function automatic logic [7:0] nonce_step(input logic [7:0] s);
        nonce_step = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    assign addr_ok = hsel & htrans[1] & hready;
    assign page_evt = rxv_q[1] & ~rxv_q[2];
    assign ack_rise = partner_nextpage_ack_in & ~ack_prev_q;

    // Read mux, decoded in the address phase so data is ready next cycle
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (haddr[7:0] == ADDR_CTRL) begin
            rdata_d = {24'h00_0000, ctrl_q};
        end else if (haddr[7:0] == ADDR_SEED) begin
            rdata_d = {24'h00_0000, nonce_seed_in};
        end else if (haddr[7:0] == ADDR_LNP_LO) begin
            rdata_d = local_nextpage_word_in[31:0];
        end else if (haddr[7:0] == ADDR_LNP_HI) begin
            rdata_d = {16'h0000, local_nextpage_word_in[LNP_W-1:32]};
        end else if (haddr[7:0] == ADDR_ACK) begin
            rdata_d = {31'h0000_0000, partner_nextpage_ack_in};
        end else if (haddr[7:0] == ADDR_STATUS) begin
            rdata_d = {25'h000_0000, pcs_st_q[1], partner_nextpage_valid_out,
                negotiation_done_out, 1'b0, state_q};
        end else if (haddr[7:0] == ADDR_PNP_LO) begin
            rdata_d = partner_nextpage_word_out[31:0];
        end else if (haddr[7:0] == ADDR_PNP_HI) begin
            rdata_d = {14'h0000, partner_nextpage_word_out[CW_W-1:32]};
        end else if (haddr[7:0] == ADDR_TXCW_LO) begin
            rdata_d = tx_codeword_out[31:0];
        end else if (haddr[7:0] == ADDR_TXCW_HI) begin
            rdata_d = {14'h0000, tx_codeword_out[CW_W-1:32]};
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rdata_d;
            end
        end
    end

    // host controls arrive as register writes in this clock domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
            nonce_seed_in <= SEED_RESET;
            local_nextpage_word_in <= '0;
            partner_nextpage_ack_in <= 1'b0;
            restart_q <= 1'b0;
        end else if (clk_en) begin
            restart_q <= 1'b0;
            if (wr_pend_q) begin
                if (wr_addr_q == ADDR_CTRL) begin
                    ctrl_q <= hwdata[7:0] & ~(8'h01 << CTRL_RESTART);
                    restart_q <= hwdata[CTRL_RESTART];
                end else if (wr_addr_q == ADDR_SEED) begin
                    nonce_seed_in <= hwdata[7:0];
                end else if (wr_addr_q == ADDR_LNP_LO) begin
                    local_nextpage_word_in[31:0] <= hwdata;
                end else if (wr_addr_q == ADDR_LNP_HI) begin
                    local_nextpage_word_in[LNP_W-1:32] <= hwdata[15:0];
                end else if (wr_addr_q == ADDR_ACK) begin
                    partner_nextpage_ack_in <= hwdata[0];
                end
            end
        end
    end

    // Link inputs come from another domain: two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxcw_s1_q <= '0;
            rxcw_s2_q <= '0;
            rxv_q <= 3'b000;
            pcs_st_q <= 2'b00;
            ack_prev_q <= 1'b0;
        end else if (clk_en) begin
            rxcw_s1_q <= rx_codeword_in;
            rxcw_s2_q <= rxcw_s1_q;
            rxv_q <= {rxv_q[1:0], rx_page_valid_in};
            pcs_st_q <= {pcs_st_q[0], pcs_rx_status_in};
            ack_prev_q <= partner_nextpage_ack_in;
        end
    end

    // Transmit codeword build
    always_comb begin
        tx_cw_d = '0;
        if (state_q == st_next) begin
            if (ctrl_q[CTRL_LOC_NP]) begin
                tx_cw_d[LNP_W-1:0] = local_nextpage_word_in;
            end else begin
                tx_cw_d[10:0] = NULL_MSG_CODE;
            end
        end else begin
            tx_cw_d[4:0] = SELECTOR_ETH;
            tx_cw_d[CW_ECHO_LSB +: 5] = partner_nextpage_word_out[CW_NONCE_LSB +: 5];
            tx_cw_d[CW_C0] = ctrl_q[CTRL_PAUSE];
            tx_cw_d[CW_C1] = ctrl_q[CTRL_ASYM];
            tx_cw_d[CW_FAULT] = ctrl_q[CTRL_FAULT];
            tx_cw_d[CW_NP] = ctrl_q[CTRL_LOC_NP];
            tx_cw_d[CW_NONCE_LSB +: 5] = nonce_q[4:0];
        end
        tx_cw_d[CW_ACK] = cw_ack_q;
        tx_cw_d[CW_RAND] = rand_q[6];
    end

    // Random bit and nonce generators
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nonce_q <= SEED_RESET;
            rand_q <= RAND_RESET;
        end else if (clk_en) begin
            rand_q <= rand_step(rand_q, ctrl_q[CTRL_POLY_SEL]);
            if (restart_q || state_q == st_off) begin
                nonce_q <= nonce_seed_in;
            end else if (page_evt && state_q == st_base) begin
                nonce_q <= nonce_step(nonce_q);
            end
        end
    end

    // Negotiation state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= st_off;
            cw_ack_q <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl_q[CTRL_ENABLE]) begin
                state_q <= st_off;
                cw_ack_q <= 1'b0;
            end else if (ctrl_q[CTRL_BYPASS]) begin
                state_q <= st_bypass;
                cw_ack_q <= 1'b0;
            end else if (restart_q) begin
                state_q <= st_base;
                cw_ack_q <= 1'b0;
            end else begin
                case (state_q)
                    st_off, st_bypass: begin
                        state_q <= st_base;
                        cw_ack_q <= 1'b0;
                    end
                    st_base: begin
                        if (page_evt) begin
                            cw_ack_q <= 1'b0;
                            // no exchange unless a side asks
                            if (ctrl_q[CTRL_LOC_NP] || rxcw_s2_q[CW_NP]) begin
                                state_q <= st_next;
                            end else begin
                                state_q <= st_good;
                            end
                        end
                    end
                    st_next: begin
                        if (ack_rise) begin
                            cw_ack_q <= 1'b1;
                            if (!ctrl_q[CTRL_LOC_NP] && !partner_nextpage_word_out[CW_NP]) begin
                                state_q <= st_good;
                            end
                        end else if (page_evt && cw_ack_q) begin
                            cw_ack_q <= 1'b0;
                        end
                    end
                    default: begin
                        state_q <= st_good;
                    end
                endcase
            end
        end
    end

    // Partner page capture and valid flag; a new page wins over the ack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            partner_nextpage_word_out <= '0;
            partner_nextpage_valid_out <= 1'b0;
        end else if (clk_en) begin
            if (page_evt && (state_q == st_base || state_q == st_next)) begin
                partner_nextpage_word_out <= rxcw_s2_q;
            end
            if (state_q == st_off || state_q == st_bypass || restart_q) begin
                partner_nextpage_valid_out <= 1'b0;
            end else if (page_evt && state_q == st_next) begin
                partner_nextpage_valid_out <= 1'b1;
            end else if (ack_rise) begin
                partner_nextpage_valid_out <= 1'b0;
            end
        end
    end

    // Link-facing outputs, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_codeword_out <= '0;
            tx_page_enable_out <= 1'b0;
            pcs_bypass_out <= 1'b0;
            negotiation_done_out <= 1'b0;
        end else if (clk_en) begin
            tx_codeword_out <= tx_cw_d;
            tx_page_enable_out <= (state_q == st_base) || (state_q == st_next);
            pcs_bypass_out <= (state_q == st_bypass);
            negotiation_done_out <= (state_q == st_good) && pcs_st_q[1];
        end
    end
endmodule
`default_nettype wire

// >>> tb/autoneg_properties.sv
`timescale 1ns/1ns
`default_nettype none
module autoneg_checker
    import an_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_page_valid_in,
    input wire logic pcs_rx_status_in,
    input wire logic [CW_W-1:0] tx_codeword_out,
    input wire logic tx_page_enable_out,
    input wire logic pcs_bypass_out,
    input wire logic negotiation_done_out,
    input wire logic partner_nextpage_valid_out
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Status low long enough to clear the synchroniser
    sequence pcs_low;
        !pcs_rx_status_in [*5];
    endsequence
    // A partner page edge that has just left the synchroniser
    sequence page_seen;
        $past(rx_page_valid_in, 3) && !$past(rx_page_valid_in, 4);
    endsequence
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    bypass_quiet_a: assert property (pcs_bypass_out |-> !tx_page_enable_out)
        else $error("pages sent while bypassed");
    done_wait_a: assert property (pcs_low |-> !negotiation_done_out)
        else $error("done without receive status");
    done_rise_a: assert property ($rose(negotiation_done_out) |-> $past(pcs_rx_status_in, 3))
        else $error("done rose too early");
    valid_cause_a: assert property ($rose(partner_nextpage_valid_out) |-> page_seen)
        else $error("partner valid rose with no page");
    ack_clear_a: assert property ($rose(tx_codeword_out[CW_ACK]) |-> ##[0:2] !partner_nextpage_valid_out)
        else $error("partner valid kept after ack");
    // Pages start with a base page: the first word sent when page enable rises carries the Ethernet selector
    selector_a: assert property ($rose(tx_page_enable_out) |-> tx_codeword_out[4:0] == SELECTOR_ETH)
        else $error("wrong selector in sent page");
endmodule
bind backplane_autoneg_control autoneg_checker u_autoneg_checker (.hclk, .hresetn, .hreadyout,
    .hresp, .rx_page_valid_in, .pcs_rx_status_in, .tx_codeword_out, .tx_page_enable_out,
    .pcs_bypass_out, .negotiation_done_out, .partner_nextpage_valid_out);
`default_nettype wire

// >>> tb/partner_model.sv
`timescale 1ns/1ns
`default_nettype none
module partner_model
    import an_ctrl_pkg::*;
(
    input wire logic hclk,
    output logic [CW_W-1:0] rx_codeword_in,
    output logic rx_page_valid_in
);
    initial begin
        rx_codeword_in = '0;
        rx_page_valid_in = 1'b0;
    end
    // Word settles before the valid edge and is inverted once
    // taken, so a stale word can never pass for a new one
    task automatic send(input logic [CW_W-1:0] cw);
        @(posedge hclk);
        rx_codeword_in <= cw;
        repeat (3) @(posedge hclk);
        rx_page_valid_in <= 1'b1;
        repeat (6) @(posedge hclk);
        rx_page_valid_in <= 1'b0;
        rx_codeword_in <= ~cw;
        repeat (4) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/test_backplane_autoneg_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_backplane_autoneg_control;
    import an_ctrl_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic pcs_rx_status_in = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [CW_W-1:0] rx_cw;
    logic rx_v;
    logic [CW_W-1:0] tx;
    logic page_en;
    logic bypass;
    logic done;
    logic npv;
    int fail_count = 0;
    int checks = 0;
    int fld[3] = '{CTRL_FAULT, CTRL_ASYM, CTRL_PAUSE};
    logic [19:0] rb;
    always #10 hclk = ~hclk;
    // Bus, size and enable tied: one slave, word accesses only
    backplane_autoneg_control u_backplane_autoneg_control (.hclk(hclk), .hresetn(hresetn),
        .clk_en(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_codeword_in(rx_cw), .rx_page_valid_in(rx_v),
        .pcs_rx_status_in(pcs_rx_status_in), .tx_codeword_out(tx), .tx_page_enable_out(page_en),
        .pcs_bypass_out(bypass), .negotiation_done_out(done), .partner_nextpage_valid_out(npv));
    partner_model u_partner_model (.hclk(hclk), .rx_codeword_in(rx_cw), .rx_page_valid_in(rx_v));
    task automatic stop_test();
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [CW_W-1:0] e, input logic [CW_W-1:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Bounded wait for ready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                stop_test();
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        cmp("hrdata", CW_W'(e), CW_W'(r));
    endtask
    // Bit 49 must follow the chosen recurrence over many cycles
    task automatic rnd(input int sel);
        wr(ADDR_CTRL, 32'h0000_0001 | (sel << CTRL_POLY_SEL));
        repeat (10) @(posedge hclk);
        for (int i = 0; i < 20; i++) begin
            @(posedge hclk);
            rb[i] = tx[CW_RAND];
        end
        for (int i = 0; i < 13; i++) begin
            cmp("rand", CW_W'(rb[i] ^ (sel ? rb[i+1] : rb[i+4])), CW_W'(rb[i+7]));
        end
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_STATUS, 32'h0000_0000);
        rd(ADDR_SEED, 32'h0000_0001);
        rd(8'h30, 32'h0000_0000);
        wr(ADDR_SEED, 32'h0000_00A5);
        rd(ADDR_SEED, 32'h0000_00A5);
        wr(ADDR_CTRL, 32'h0000_0003);
        repeat (4) @(posedge hclk);
        cmp("bypass", 1, bypass);
        cmp("page_en", 0, page_en);
        rd(ADDR_STATUS, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, 32'h0000_0001 | (32'h0000_0001 << fld[i]));
            repeat (4) @(posedge hclk);
            cmp("ability", CW_W'(3'h4 >> i), CW_W'({tx[CW_FAULT], tx[CW_C1], tx[CW_C0]}));
        end
        rd(ADDR_STATUS, 32'h0000_0002);
        rnd(0);
        rnd(1);
        wr(ADDR_CTRL, 32'h0000_0001);
        u_partner_model.send(CW_W'(32'h0000_4001));
        rd(ADDR_STATUS, 32'h0000_0004);
        cmp("done", 0, done);
        pcs_rx_status_in <= 1'b1;
        repeat (6) @(posedge hclk);
        cmp("done", 1, done);
        pcs_rx_status_in <= 1'b0;
        repeat (6) @(posedge hclk);
        wr(ADDR_CTRL, 32'h0000_0005);
        repeat (3) @(posedge hclk);
        rd(ADDR_STATUS, 32'h0000_0002);
        rd(ADDR_CTRL, 32'h0000_0001);
        u_partner_model.send(CW_W'(32'h0000_8007));
        rd(ADDR_STATUS, 32'h0000_0003);
        cmp("null", CW_W'(NULL_MSG_CODE), CW_W'(tx[10:0]));
        rd(ADDR_PNP_LO, 32'h0000_8007);
        wr(ADDR_ACK, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        cmp("np_valid", 0, npv);
        cmp("ack_bit", 1, tx[CW_ACK]);
        repeat (10) @(posedge hclk);
        cmp("np_valid", 0, npv);
        wr(ADDR_ACK, 32'h0000_0000);
        u_partner_model.send(CW_W'(32'h0000_0009));
        cmp("ack_bit", 0, tx[CW_ACK]);
        cmp("np_valid", 1, npv);
        rd(ADDR_PNP_LO, 32'h0000_0009);
        wr(ADDR_ACK, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        cmp("np_valid", 0, npv);
        rd(ADDR_STATUS, 32'h0000_0004);
        wr(ADDR_LNP_LO, 32'h0000_0123);
        wr(ADDR_LNP_HI, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0085);
        repeat (3) @(posedge hclk);
        cmp("np_bit", 1, tx[CW_NP]);
        u_partner_model.send(CW_W'(32'h0000_0001));
        rd(ADDR_STATUS, 32'h0000_0003);
        cmp("np_word", CW_W'(11'h123), CW_W'(tx[10:0]));
        wr(ADDR_CTRL, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        rd(ADDR_STATUS, 32'h0000_0000);
        cmp("page_en", 0, page_en);
        stop_test();
    end
endmodule
`default_nettype wire
